// [design/vco_cal_pkg.sv]
// Constants, register map and types shared by the calibration sequencer and its helpers.
// Assumes a 40 MHz system clock and registers that are one byte wide.
package vco_cal_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;

  // Register indices; the Wishbone byte address is four times the index.
  localparam logic [9:0] IDX_CAL_CTRL = 10'h018;
  localparam logic [9:0] IDX_MON_CTRL = 10'h01a;
  localparam logic [9:0] IDX_ZD_CTRL = 10'h01e;
  localparam logic [9:0] IDX_STATUS = 10'h01f;
  localparam logic [9:0] IDX_VCO_DIV = 10'h1e0;
  localparam logic [9:0] IDX_SRC_SEL = 10'h1e1;
  localparam logic [9:0] IDX_UPDATE = 10'h232;
  localparam logic [9:0] IDX_R_DIV = 10'h0f0;
  localparam logic [9:0] IDX_REF_DLY = 10'h0f1;
  localparam logic [9:0] IDX_FB_DLY = 10'h0f2;

  // Slots of the shadow and active register arrays.
  localparam logic [2:0] SLOT_CAL = 3'h0;
  localparam logic [2:0] SLOT_MON = 3'h1;
  localparam logic [2:0] SLOT_ZD = 3'h2;
  localparam logic [2:0] SLOT_VDIV = 3'h3;
  localparam logic [2:0] SLOT_SRC = 3'h4;
  localparam logic [2:0] SLOT_RDIV = 3'h5;
  localparam logic [2:0] SLOT_RDLY = 3'h6;
  localparam logic [2:0] SLOT_FDLY = 3'h7;

  // Reset values, slot 7 down to slot 0.
  localparam logic [7:0][7:0] SHADOW_RST = {8'h00, 8'h00, 8'h01, 8'h02,
                                            8'h01, 8'h00, 8'h00, 8'h06};

  // Field positions.
  localparam int unsigned CAL_START_BIT = 0;
  localparam int unsigned CAL_DIV_LSB = 1;
  localparam int unsigned MON_EXT_BIT = 6;
  localparam int unsigned ZD_MODE_LSB = 1;
  localparam int unsigned ZD_CHAN_LSB = 3;
  localparam int unsigned DONE_BIT = 6;
  localparam int unsigned UPDATE_BIT = 0;
  localparam int unsigned SRC_VCO_BIT = 1;

  localparam logic [1:0] ZD_INTERNAL = 2'h1;
  localparam logic [1:0] ZD_EXTERNAL = 2'h3;

  localparam logic [12:0] CAL_CYCLES = 13'h1130;

  // Longest edge gap before an input counts as too slow, in ns and in cycles.
  localparam int unsigned REF_MON_NORMAL_NS = 2000;
  localparam int unsigned REF_MON_EXT_NS = 20000;
  localparam int unsigned VCO_MON_NS = 2000;
  localparam logic [11:0] REF_MON_NORMAL_CYC = 12'(REF_MON_NORMAL_NS / CLK_PERIOD_NS);
  localparam logic [11:0] REF_MON_EXT_CYC = 12'(REF_MON_EXT_NS / CLK_PERIOD_NS);
  localparam logic [11:0] VCO_MON_CYC = 12'(VCO_MON_NS / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_TUNE = 2'b01,
    CAL_RELEASE = 2'b10
  } cal_state_t;

  // Divide ratio of the calibration divider field: 2, 4, 8 or 16.
  function automatic logic [4:0] cal_ratio(input logic [1:0] sel);
    return 5'h02 << sel;
  endfunction

endpackage

// [design/cal_clk_if.sv]
// Link between the sequencer and its calibration clock divider.
// Both ends sit on the same system clock.
`timescale 1ns/10ps
interface cal_clk_if;
  logic ref_tick;
  logic run;
  logic [7:0] r_div;
  logic [1:0] cal_sel;
  logic cal_tick;
  modport ctrl (output ref_tick, run, r_div, cal_sel, input cal_tick);
  modport div (input ref_tick, run, r_div, cal_sel, output cal_tick);
endinterface

// [design/cal_clk_divider.sv]
// Divides reference edges by R and then by the calibration ratio into a one-cycle tick.
// Assumes ref_tick is a single-cycle pulse, never on two cycles in a row.
`timescale 1ns/10ps
module cal_clk_divider (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  cal_clk_if.div link // Control in, tick out.
);
  typedef struct packed {
    logic [7:0] r_cnt;
    logic [4:0] c_cnt;
    logic tick;
  } div_state_t;

  div_state_t s_reg;
  div_state_t s_next;
  logic [7:0] r_eff;
  logic [4:0] ratio;

  always_comb
  begin
    r_eff = (link.r_div == 8'h00) ? 8'h01 : link.r_div;
    ratio = vco_cal_pkg::cal_ratio(link.cal_sel);
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!link.run)
    begin
      s_next.r_cnt = 8'h00;
      s_next.c_cnt = 5'h00;
    end
    else if (link.ref_tick)
    begin
      if (s_reg.r_cnt >= r_eff - 8'h01)
      begin
        s_next.r_cnt = 8'h00;
        if (s_reg.c_cnt >= ratio - 5'h01)
        begin
          s_next.c_cnt = 5'h00;
          s_next.tick = 1'b1;
        end
        else
          s_next.c_cnt = s_reg.c_cnt + 5'h01;
      end
      else
        s_next.r_cnt = s_reg.r_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign link.cal_tick = s_reg.tick;

  a_tick_spacing: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    link.cal_tick |=> !link.cal_tick[*2])
    else $error("Calibration ticks closer than the smallest ratio allows.");

  a_tick_needs_run: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    link.cal_tick |-> $past(link.run) && $past(link.ref_tick, 2) == 1'b0)
    else $error("Calibration tick without a running divider.");

endmodule // cal_clk_divider

// [design/freq_monitor.sv]
// Flags an input whose edges stop arriving within a programmable number of cycles.
// Assumes edge_in is a synchronised single-cycle pulse.
`timescale 1ns/10ps
module freq_monitor (
  input wire logic clk_sys_in, // System clock.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic edge_in, // One pulse per input edge.
  input wire logic [11:0] thresh_in, // Longest allowed gap in cycles.
  output logic below_out // High while the input is too slow.
);
  typedef struct packed {
    logic [11:0] cnt;
    logic below;
  } mon_state_t;

  mon_state_t s_reg;
  mon_state_t s_next;

  always_comb
  begin
    s_next = s_reg;
    if (edge_in)
    begin
      s_next.cnt = 12'h000;
      s_next.below = 1'b0;
    end
    else if (s_reg.cnt >= thresh_in)
      s_next.below = 1'b1;
    else
      s_next.cnt = s_reg.cnt + 12'h001;
  end

  // Starts flagged so that no input is trusted before its first edge.
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      s_reg <= '{cnt: 12'h000, below: 1'b1};
    else
      s_reg <= s_next;
  end

  assign below_out = s_reg.below;

  a_flag_on_edge: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    edge_in |=> !below_out)
    else $error("Monitor stayed flagged after an edge.");

endmodule // freq_monitor

// [design/vco_calibration_sequencer.sv]
// VCO calibration sequencer with its register file, frequency monitors and
// zero delay feedback selection. Registers are reached over classic Wishbone;
// reference and sense inputs are asynchronous pins and are synchronised here.
//
// Decided for this implementation: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps

module vco_calibration_sequencer (
  input wire logic clk_sys_in, // System clock, 40 MHz.
  input wire logic rst_n_in, // Synchronous reset, active low.
  input wire logic wb_cyc_in, // Wishbone cycle.
  input wire logic wb_stb_in, // Wishbone strobe.
  input wire logic wb_we_in, // Wishbone write enable.
  input wire logic [11:0] wb_adr_in, // Wishbone byte address.
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_in, // Wishbone write data.
  output logic [31:0] wb_dat_out, // Wishbone read data.
  output logic wb_ack_out, // Wishbone acknowledge.
  input wire logic pll_reference_input_a_in, // Reference A pin.
  input wire logic pll_reference_input_b_in, // Reference B pin.
  input wire logic vco_sense_in, // Divided VCO sense pin.
  input wire logic clk_pin_sense_in, // Divided external clock pin sense.
  input wire logic eeprom_auto_cal_in, // Stored setup asks for auto calibration.
  input wire logic eeprom_load_done_in, // Pulse: stored setup has been loaded.
  output logic dist_sync_out, // Distribution held in sync.
  output logic loop_closed_out, // PLL loop closed.
  output logic cal_done_out, // Calibration finished.
  output logic feedback_source_mux_a_out, // 0 channel divider 0, 1 clock pins.
  output logic feedback_source_mux_b_out, // 0 normal feedback, 1 zero delay path.
  output logic [1:0] zd_channel_sel_out, // Channel divider used for feedback.
  output logic [7:0] ref_delay_out, // Reference path delay setting.
  output logic [7:0] fb_delay_out, // Feedback path delay setting.
  output logic [7:0] r_div_out, // Active R divider value.
  output logic [2:0] vco_div_out, // Active VCO divider field.
  output logic [1:0] clk_source_sel_out, // Active distribution source field.
  output logic [2:0] freq_low_out // Slow flags: ref A, ref B, VCO or clock pins.
);
  typedef struct packed {
    logic [2:0] sync_ra;
    logic [2:0] sync_rb;
    logic [2:0] sync_vco;
    logic [2:0] sync_clkp;
    logic ack;
    logic [31:0] dat;
    logic [7:0][7:0] sh;
    logic [7:0][7:0] ac;
    logic upd;
    vco_cal_pkg::cal_state_t st;
    logic [12:0] cnt;
    logic done;
    logic sync;
    logic closed;
    logic fb_a;
    logic fb_b;
    logic [1:0] zd_chan;
  } seq_state_t;

  seq_state_t s_reg;
  seq_state_t s_next;
  cal_clk_if clk_link ();
  logic [2:0] mon_edge;
  logic [2:0] mon_low;
  logic [11:0] mon_thresh [3];
  logic req;
  logic wr_en;
  logic [9:0] idx;
  logic [3:0] wr_slot;
  logic [3:0] rd_slot;
  logic [7:0] rd_byte;
  logic commit;
  logic start_rise;
  logic auto_go;
  logic cal_start;
  logic [1:0] zd_mode;

  // Returns {valid, slot} for a register index that lives in the byte arrays.
  function automatic logic [3:0] slot_of(input logic [9:0] i);
    case (i)
      vco_cal_pkg::IDX_CAL_CTRL: slot_of = {1'b1, vco_cal_pkg::SLOT_CAL};
      vco_cal_pkg::IDX_MON_CTRL: slot_of = {1'b1, vco_cal_pkg::SLOT_MON};
      vco_cal_pkg::IDX_ZD_CTRL: slot_of = {1'b1, vco_cal_pkg::SLOT_ZD};
      vco_cal_pkg::IDX_VCO_DIV: slot_of = {1'b1, vco_cal_pkg::SLOT_VDIV};
      vco_cal_pkg::IDX_SRC_SEL: slot_of = {1'b1, vco_cal_pkg::SLOT_SRC};
      vco_cal_pkg::IDX_R_DIV: slot_of = {1'b1, vco_cal_pkg::SLOT_RDIV};
      vco_cal_pkg::IDX_REF_DLY: slot_of = {1'b1, vco_cal_pkg::SLOT_RDLY};
      vco_cal_pkg::IDX_FB_DLY: slot_of = {1'b1, vco_cal_pkg::SLOT_FDLY};
      default: slot_of = 4'h0;
    endcase
  endfunction

  // Only the second and third synchroniser stages feed the edge detectors.
  assign mon_edge[0] = s_reg.sync_ra[1] & ~s_reg.sync_ra[2];
  assign mon_edge[1] = s_reg.sync_rb[1] & ~s_reg.sync_rb[2];
  assign mon_edge[2] = s_reg.ac[vco_cal_pkg::SLOT_SRC][vco_cal_pkg::SRC_VCO_BIT] ?
                       (s_reg.sync_vco[1] & ~s_reg.sync_vco[2]) :
                       (s_reg.sync_clkp[1] & ~s_reg.sync_clkp[2]);

  assign mon_thresh[0] = s_reg.ac[vco_cal_pkg::SLOT_MON][vco_cal_pkg::MON_EXT_BIT] ?
                         vco_cal_pkg::REF_MON_EXT_CYC : vco_cal_pkg::REF_MON_NORMAL_CYC;
  assign mon_thresh[1] = mon_thresh[0];
  assign mon_thresh[2] = vco_cal_pkg::VCO_MON_CYC;

  generate
    for (genvar g = 0; g < 3; g++)
    begin : gen_mon
      freq_monitor u_mon (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .edge_in(mon_edge[g]),
        .thresh_in(mon_thresh[g]),
        .below_out(mon_low[g])
      );
    end
  endgenerate

  // The calibration clock follows reference A only while tuning.
  assign clk_link.ref_tick = mon_edge[0];
  assign clk_link.run = (s_reg.st == vco_cal_pkg::CAL_TUNE);
  assign clk_link.r_div = s_reg.ac[vco_cal_pkg::SLOT_RDIV];
  assign clk_link.cal_sel = s_reg.ac[vco_cal_pkg::SLOT_CAL][vco_cal_pkg::CAL_DIV_LSB +: 2];

  cal_clk_divider u_div (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .link(clk_link)
  );

  // Bus decode. A write takes effect at the edge where ack is high.
  assign req = wb_cyc_in & wb_stb_in;
  assign idx = wb_adr_in[11:2];
  assign wr_en = req & wb_we_in & s_reg.ack & wb_sel_in[0];
  assign wr_slot = slot_of(idx);
  assign rd_slot = slot_of(idx);

  // Start is the committed rising transition of the start bit, never a divider change.
  assign commit = s_reg.upd;
  assign start_rise = commit & s_reg.sh[vco_cal_pkg::SLOT_CAL][vco_cal_pkg::CAL_START_BIT] &
                      ~s_reg.ac[vco_cal_pkg::SLOT_CAL][vco_cal_pkg::CAL_START_BIT];
  // The auto path needs a live reference; otherwise software must start by hand.
  assign auto_go = eeprom_load_done_in & eeprom_auto_cal_in & ~mon_low[0];
  assign cal_start = start_rise | auto_go;

  always_comb
  begin
    rd_byte = 8'h00;
    if (rd_slot[3])
      rd_byte = s_reg.sh[rd_slot[2:0]];
    else if (idx == vco_cal_pkg::IDX_STATUS)
    begin
      rd_byte[vco_cal_pkg::DONE_BIT] = s_reg.done;
      rd_byte[2:0] = mon_low;
    end
    else if (idx == vco_cal_pkg::IDX_UPDATE)
      rd_byte[vco_cal_pkg::UPDATE_BIT] = s_reg.upd;
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.sync_ra = {s_reg.sync_ra[1:0], pll_reference_input_a_in};
    s_next.sync_rb = {s_reg.sync_rb[1:0], pll_reference_input_b_in};
    s_next.sync_vco = {s_reg.sync_vco[1:0], vco_sense_in};
    s_next.sync_clkp = {s_reg.sync_clkp[1:0], clk_pin_sense_in};

    // One wait state, ack for one cycle; unmapped reads return zero.
    s_next.ack = req & ~s_reg.ack;
    if (req & ~s_reg.ack)
      s_next.dat = {24'h000000, rd_byte};

    // The update bit clears itself one cycle after it is written.
    s_next.upd = 1'b0;
    if (wr_en)
    begin
      if (wr_slot[3])
        s_next.sh[wr_slot[2:0]] = wb_dat_in[7:0];
      else if (idx == vco_cal_pkg::IDX_UPDATE)
        s_next.upd = wb_dat_in[vco_cal_pkg::UPDATE_BIT];
    end
    if (commit)
      s_next.ac = s_reg.sh;

    if (cal_start)
    begin
      s_next.st = vco_cal_pkg::CAL_TUNE;
      s_next.cnt = 13'h0000;
      s_next.done = 1'b0;
      s_next.sync = 1'b1;
      s_next.closed = 1'b0;
    end
    else
    begin
      case (s_reg.st)
        vco_cal_pkg::CAL_IDLE:
          s_next.st = vco_cal_pkg::CAL_IDLE;
        vco_cal_pkg::CAL_TUNE:
          if (clk_link.cal_tick)
          begin
            if (s_reg.cnt == vco_cal_pkg::CAL_CYCLES - 13'h0001)
            begin
              s_next.st = vco_cal_pkg::CAL_RELEASE;
              s_next.sync = 1'b0;
              s_next.done = 1'b1;
            end
            else
              s_next.cnt = s_reg.cnt + 13'h0001;
          end
        vco_cal_pkg::CAL_RELEASE:
        begin
          // Outputs restart a cycle before the loop closes, so they may run unsettled.
          s_next.st = vco_cal_pkg::CAL_IDLE;
          s_next.closed = 1'b1;
        end
        default:
          s_next.st = vco_cal_pkg::CAL_IDLE;
      endcase
    end

    // Routing follows the committed mode, so the muxes switch on the commit edge.
    zd_mode = s_next.ac[vco_cal_pkg::SLOT_ZD][vco_cal_pkg::ZD_MODE_LSB +: 2];
    s_next.fb_b = (zd_mode == vco_cal_pkg::ZD_INTERNAL) ||
                  (zd_mode == vco_cal_pkg::ZD_EXTERNAL);
    s_next.fb_a = (zd_mode == vco_cal_pkg::ZD_EXTERNAL);
    // Channels 1 to 3 only reach the loop through the clock pins.
    s_next.zd_chan = (zd_mode == vco_cal_pkg::ZD_EXTERNAL) ?
                     s_next.ac[vco_cal_pkg::SLOT_ZD][vco_cal_pkg::ZD_CHAN_LSB +: 2] : 2'h0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      s_reg <= '0;
      s_reg.sh <= vco_cal_pkg::SHADOW_RST;
      s_reg.ac <= vco_cal_pkg::SHADOW_RST;
      s_reg.st <= vco_cal_pkg::CAL_IDLE;
      s_reg.closed <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign wb_dat_out = s_reg.dat;
  assign wb_ack_out = s_reg.ack;
  assign dist_sync_out = s_reg.sync;
  assign loop_closed_out = s_reg.closed;
  assign cal_done_out = s_reg.done;
  assign feedback_source_mux_a_out = s_reg.fb_a;
  assign feedback_source_mux_b_out = s_reg.fb_b;
  assign zd_channel_sel_out = s_reg.zd_chan;
  assign ref_delay_out = s_reg.ac[vco_cal_pkg::SLOT_RDLY];
  assign fb_delay_out = s_reg.ac[vco_cal_pkg::SLOT_FDLY];
  assign r_div_out = s_reg.ac[vco_cal_pkg::SLOT_RDIV];
  assign vco_div_out = s_reg.ac[vco_cal_pkg::SLOT_VDIV][2:0];
  assign clk_source_sel_out = s_reg.ac[vco_cal_pkg::SLOT_SRC][1:0];
  assign freq_low_out = mon_low;

  a_start_sync: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    cal_start |=> dist_sync_out && !loop_closed_out && !cal_done_out)
    else $error("Calibration start did not force sync and clear done.");

  a_done_low_run: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    dist_sync_out |-> !cal_done_out)
    else $error("Done reads one while calibrating.");

  a_start_needs_upd: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(dist_sync_out) |-> $past(s_reg.upd) || $past(auto_go))
    else $error("Calibration began without a committed update.");

  a_no_retrigger: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    (commit && s_reg.ac[vco_cal_pkg::SLOT_CAL][vco_cal_pkg::CAL_START_BIT] && !auto_go)
    |=> !(s_reg.st == vco_cal_pkg::CAL_TUNE && s_reg.cnt == 13'h0000 && $rose(dist_sync_out)))
    else $error("Start bit held at one restarted calibration.");

  a_release_close: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(dist_sync_out) |-> !loop_closed_out ##1 loop_closed_out)
    else $error("Loop not closed one cycle after sync release.");

  a_tune_length: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(dist_sync_out) |-> $past(s_reg.cnt) == vco_cal_pkg::CAL_CYCLES - 13'h0001)
    else $error("Calibration ended after the wrong tick count.");

  a_done_status: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(dist_sync_out) |-> cal_done_out)
    else $error("Done not set at end of calibration.");

  a_auto_cal: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    auto_go |=> dist_sync_out && s_reg.cnt == 13'h0000)
    else $error("Auto load did not start calibration.");

  a_zd_internal: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_reg.ac[vco_cal_pkg::SLOT_ZD][vco_cal_pkg::ZD_MODE_LSB +: 2] == vco_cal_pkg::ZD_INTERNAL
    |-> feedback_source_mux_b_out && !feedback_source_mux_a_out && zd_channel_sel_out == 2'h0)
    else $error("Internal zero delay feedback not routed.");

  a_zd_external: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_reg.ac[vco_cal_pkg::SLOT_ZD][vco_cal_pkg::ZD_MODE_LSB +: 2] == vco_cal_pkg::ZD_EXTERNAL
    |-> feedback_source_mux_b_out && feedback_source_mux_a_out)
    else $error("External zero delay feedback not routed.");

  a_ack_one: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    req && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
    else $error("Bus acknowledge not a single cycle after one wait.");

  a_sync_held: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(dist_sync_out) |-> $past(clk_link.cal_tick))
    else $error("Sync released before the last calibration tick.");

  a_commit_copy: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    commit |=> s_reg.ac == $past(s_reg.sh))
    else $error("Update did not commit the shadow registers.");

  a_ext_chan: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    s_reg.ac[vco_cal_pkg::SLOT_ZD][vco_cal_pkg::ZD_MODE_LSB +: 2] != vco_cal_pkg::ZD_EXTERNAL
    |-> zd_channel_sel_out == 2'h0)
    else $error("Channel select used outside external zero delay mode.");

  a_no_auto_low: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    eeprom_load_done_in && mon_low[0] && !start_rise && !dist_sync_out |=> !dist_sync_out)
    else $error("Auto path started a calibration without a reference.");

  c_cal_done: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(dist_sync_out) ##1 loop_closed_out);
  c_restart: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    dist_sync_out && cal_start);
  c_ext_zd: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    feedback_source_mux_a_out && zd_channel_sel_out != 2'h0);
  c_ref_low: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(freq_low_out[0]));
  c_auto_start: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    auto_go ##1 dist_sync_out);

endmodule // vco_calibration_sequencer

// [bench/ref_source.sv]
// Model of the external oscillator that feeds the reference pins.
// Assumes the bench gates it; while stopped it stands still at low level.
`timescale 1ns/10ps
module ref_source #(parameter int HALF_NS = 50) (
  input wire logic run_in, // Oscillator enabled.
  output logic ref_out // Reference pin level.
);
  initial ref_out = 1'b0;
  always
  begin
    #(HALF_NS);
    ref_out = run_in ? ~ref_out : 1'b0;
  end
endmodule // ref_source

// [bench/tb_top.sv]
// Self-checking bench for the calibration sequencer over classic Wishbone.
// Assumes a 10 MHz reference, R of 1 and a ratio of 2, so one run is 35200 cycles.
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic run = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, sync, closed, done, mxa, mxb, refp;
  logic [1:0] chan;
  logic [2:0] low;
  logic [2:0] vdiv;
  logic [1:0] clk_src;
  logic [7:0] rdiv, rdly, fdly;
  logic auto_cal = 1'b0;
  logic load_done = 1'b0;
  logic [7:0] q;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  localparam logic [7:0] ZV [4] = '{8'h02, 8'h1a, 8'h1e, 8'h00};
  localparam logic [7:0] ZE [4] = '{8'h08, 8'h08, 8'h0f, 8'h00};

  always #12.5 clk = ~clk;

  ref_source src (.run_in(run), .ref_out(refp));

  vco_calibration_sequencer dut (
    .clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .pll_reference_input_a_in(refp),
    .pll_reference_input_b_in(refp), .vco_sense_in(refp), .clk_pin_sense_in(1'b0),
    .eeprom_auto_cal_in(auto_cal), .eeprom_load_done_in(load_done), .dist_sync_out(sync),
    .loop_closed_out(closed), .cal_done_out(done), .feedback_source_mux_a_out(mxa),
    .feedback_source_mux_b_out(mxb), .zd_channel_sel_out(chan), .ref_delay_out(rdly),
    .fb_delay_out(fdly), .r_div_out(rdiv), .vco_div_out(vdiv), .clk_source_sel_out(clk_src),
    .freq_low_out(low));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled, then releases it for at least one cycle.
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    chk({7'h00, k < 20}, 8'h01);
  endtask

  task automatic t_reset();
    wb(1'b0, vco_cal_pkg::IDX_CAL_CTRL, 8'h00);
    chk(q, 8'h06);
    wb(1'b0, vco_cal_pkg::IDX_STATUS, 8'h00);
    chk({2'h0, q[6], sync, closed, low}, 8'h0f);
    wb(1'b0, 10'h3ff, 8'h00);
    chk(q, 8'h00);
  endtask

  task automatic t_zero_delay();
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, vco_cal_pkg::IDX_ZD_CTRL, ZV[i]);
      wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
      repeat (2) @(posedge clk);
      chk({4'h0, mxb, mxa, chan}, ZE[i]);
    end
  endtask

  task automatic t_no_start();
    wb(1'b1, vco_cal_pkg::IDX_R_DIV, 8'h01);
    wb(1'b1, vco_cal_pkg::IDX_VCO_DIV, 8'h02);
    wb(1'b1, vco_cal_pkg::IDX_REF_DLY, 8'h3c);
    wb(1'b1, vco_cal_pkg::IDX_FB_DLY, 8'h5a);
    chk(rdly, 8'h00);
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    wb(1'b1, vco_cal_pkg::IDX_CAL_CTRL, 8'h01);
    repeat (5) @(posedge clk);
    chk({7'h00, sync}, 8'h00);
    chk(rdly, 8'h3c);
    chk(fdly, 8'h5a);
    chk({vdiv, 3'h0, clk_src}, 8'h42);
    chk(rdiv, 8'h01);
  endtask

  task automatic t_first_cal();
    run <= 1'b1;
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    repeat (2) @(posedge clk);
    chk({5'h00, sync, closed, done}, 8'h04);
    n = 0;
    while (sync === 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    chk({7'h00, n > 35150 && n < 35250}, 8'h01);
    chk({6'h00, done, closed}, 8'h02);
    @(posedge clk);
    chk({7'h00, closed}, 8'h01);
    wb(1'b0, vco_cal_pkg::IDX_STATUS, 8'h00);
    chk(q, 8'h40);
    chk({5'h00, low}, 8'h00);
  endtask

  task automatic t_recal();
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    repeat (3) @(posedge clk);
    chk({7'h00, sync}, 8'h00);
    wb(1'b1, vco_cal_pkg::IDX_MON_CTRL, 8'h40);
    wb(1'b1, vco_cal_pkg::IDX_CAL_CTRL, 8'h00);
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    wb(1'b1, vco_cal_pkg::IDX_CAL_CTRL, 8'h01);
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    repeat (2) @(posedge clk);
    chk({6'h00, sync, done}, 8'h02);
    run <= 1'b0;
    repeat (300) @(posedge clk);
    chk({6'h00, sync, low[0]}, 8'h02);
    repeat (600) @(posedge clk);
    chk({6'h00, sync, low[0]}, 8'h03);
    run <= 1'b1;
    n = 0;
    while (done !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    chk({6'h00, sync, done}, 8'h01);
  endtask

  // Auto start refused without a reference, taken with one; then a reset cuts the run short.
  task automatic t_auto();
    auto_cal <= 1'b1;
    run <= 1'b0;
    repeat (900) @(posedge clk);
    load_done <= 1'b1;
    @(posedge clk);
    load_done <= 1'b0;
    repeat (3) @(posedge clk);
    chk({6'h00, sync, low[0]}, 8'h01);
    run <= 1'b1;
    repeat (20) @(posedge clk);
    load_done <= 1'b1;
    @(posedge clk);
    load_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk({5'h00, sync, done, low[0]}, 8'h04);
    wb(1'b1, vco_cal_pkg::IDX_SRC_SEL, 8'h00);
    wb(1'b1, vco_cal_pkg::IDX_UPDATE, 8'h01);
    repeat (100) @(posedge clk);
    chk({3'h0, low, clk_src}, 8'h10);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({2'h0, low, sync, closed, done}, 8'h3a);
    chk({6'h00, clk_src}, 8'h02);
    chk(rdly, 8'h00);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_zero_delay();
    t_no_start();
    t_first_cal();
    t_recal();
    t_auto();
    results();
  end

  // Two full runs take about 72000 cycles; a hang beyond 90000 is cut short.
  initial
  begin
    #(90000 * 25);
    miscompares++;
    results();
  end
endmodule // tb_top
